// File: bench/host_wake_pins.sv
`timescale 1ns/1ps
module host_wake_pins
    import power_mode_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                req_valid,
    input  wire logic [4:0]          req_pin,
    input  wire logic                req_level,
    output logic      [NUM_PINS-1:0] general_pin
);
    // ----------------------------------------------------------------
    // Host pin drive
    // ----------------------------------------------------------------
    logic   [NUM_PINS-1:0] held  = '0;
    logic   [NUM_PINS-1:0] level = '0;
    integer                seed  = 32'h90e7;

    initial general_pin = '0;

    // Pins the host does not own toggle at random, so unused wake logic sees noise
    always @(posedge clk_sys) begin
        if (req_valid) begin
            held[req_pin]  <= 1'b1;
            level[req_pin] <= req_level;
        end
        general_pin <= (held & level) | (~held & NUM_PINS'($random(seed)));
    end
endmodule

// File: bench/power_mode_wake_control_tb.sv
`timescale 1ns/1ps
module power_mode_wake_control_tb
    import power_mode_pkg::*;
;
    // ----------------------------------------------------------------
    // Setup
    // ----------------------------------------------------------------
    localparam int CAL_I   = 200;
    localparam int CAL_MIN = 50;
    localparam int CAL_D   = 20;
    localparam int XS      = 30;

    logic                     clk_sys     = 1'b0;
    logic                     sys_rst     = 1'b1;
    logic                     req_valid   = 1'b0;
    logic [4:0]               req_pin     = 5'h0;
    logic                     req_level   = 1'b0;
    logic [NUM_PINS-1:0]      wake_enable = '0;
    logic [NUM_PINS-1:0][1:0] wake_mode   = '0;
    logic                     wfe = 1'b0, pend = 1'b0, uart = 1'b0, radio = 1'b0;
    logic                     deep_req = 1'b0, xsel = 1'b0, cust = 1'b0;
    logic [IRQ_NUM-1:0]       irq         = '0;
    logic [31:0]              cal_iv      = 32'h0;
    logic [NUM_PINS-1:0]      general_pin;
    logic                     run_active, doze_active, deep_active, system_reset_req;
    logic                     wake_event, exp_w, wk_prev = 1'b0;
    logic                     exp_wake[$];
    logic [4:0]               wpin;
    logic                     cal_start, cal_busy, cal_done, crystal_osc_en, low_freq_clock_valid;
    logic [3:0]               exp_state[$];
    logic [3:0]               cur, exp;
    logic [2:0]               prev = 3'b001;
    int                       errors = 0, n_tests = 0, k;
    int                       busy_n = 0, gap_n = 0, xs_n = 0, exp_gap = CAL_I;
    bit                       gap_ok = 1'b0;
    integer                   seed = 32'h90e7;

    always #2.5 clk_sys = ~clk_sys;

    power_mode_wake_control #(.CAL_INTERVAL_CYC(32'(CAL_I)), .CAL_INTERVAL_MIN_CYC(32'(CAL_MIN)),
        .CAL_DURATION_CYC(32'(CAL_D)), .XTAL_STARTUP_CYC(32'(XS))) u_dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .general_pin(general_pin),
        .wake_enable(wake_enable), .wake_mode(wake_mode), .wait_for_event_point(wfe),
        .events_pending(pend), .irq_lines(irq), .uart_rx_char(uart), .radio_rx_char(radio),
        .deep_sleep_req(deep_req), .crystal_select(xsel), .cal_interval_custom_en(cust),
        .cal_interval(cal_iv), .run_active(run_active), .doze_active(doze_active),
        .deep_active(deep_active), .system_reset_req(system_reset_req), .wake_event(wake_event),
        .cal_start(cal_start), .cal_busy(cal_busy), .cal_done(cal_done),
        .crystal_osc_en(crystal_osc_en), .low_freq_clock_valid(low_freq_clock_valid));

    host_wake_pins u_host (.clk_sys(clk_sys), .req_valid(req_valid), .req_pin(req_pin),
        .req_level(req_level), .general_pin(general_pin));

    // ----------------------------------------------------------------
    // Compare and drive tasks
    // ----------------------------------------------------------------
    task automatic results();
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check_state(input logic [3:0] e, input logic [3:0] s);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED state expected %b seen %b", e, s);
        end
    endtask

    task automatic check_wake(input logic e, input logic s);
        n_tests++;
        if (s !== e) begin
            errors++;
            $display("CHECK FAILED wake event expected %b seen %b", e, s);
        end
    endtask

    task automatic check_val(input string name, input int e, input int s, input int tol);
        n_tests++;
        if (s < e - tol || s > e + tol) begin
            errors++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, e, s);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Bounded wait; a missing state change is a mismatch, not a hang
    task automatic settle();
        int t;
        for (t = 0; t < 16 && exp_state.size() != 0; t++) tick(1);
        if (exp_state.size() != 0) begin
            check_val("pending state changes", 0, exp_state.size(), 0);
            exp_state.delete();
        end
        tick(2);
        if (exp_wake.size() != 0) begin
            check_val("pending wake events", 0, exp_wake.size(), 0);
            exp_wake.delete();
        end
    endtask

    task automatic enter_doze();
        exp_state.push_back(4'b0010);
        wfe <= 1'b1;
        tick(1);
        wfe <= 1'b0;
        settle();
    endtask

    task automatic host_pin(input logic [4:0] i, input logic l);
        req_valid <= 1'b1;
        req_pin   <= i;
        req_level <= l;
        tick(1);
        req_valid <= 1'b0;
        tick(4);
    endtask

    // Pin index kept static; an automatic index on a nonblocking target is not portable
    task automatic pin_wake(input logic [1:0] m, input logic [3:0] e);
        wpin = 5'($unsigned($random(seed)) % NUM_PINS);
        host_pin(wpin, m == WAKE_ON_LOW);
        wake_mode[wpin] <= m;
        wake_enable     <= {{(NUM_PINS-1){1'b0}}, 1'b1} << wpin;
        tick(6);
        if (m != 2'h3) begin
            exp_state.push_back(e);
            exp_wake.push_back(1'b1);
        end
        host_pin(wpin, m != WAKE_ON_LOW);
        settle();
        wake_enable <= '0;
    endtask

    // ----------------------------------------------------------------
    // Output watcher
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        #1;
        if (!sys_rst) begin
            cur = {system_reset_req, deep_active, doze_active, run_active};
            if (cur[2:0] !== prev) begin
                exp = (exp_state.size() != 0) ? exp_state.pop_front() : 4'h0;
                check_state(exp, cur);
                prev = cur[2:0];
            end
            if (wake_event === 1'b1 && !wk_prev) begin
                exp_w = (exp_wake.size() != 0) ? exp_wake.pop_front() : 1'b0;
                check_wake(exp_w, wake_event);
            end
            wk_prev = (wake_event === 1'b1);
            if (cal_busy === 1'b1) busy_n++;
            if (cal_start === 1'b1 && gap_ok) check_val("cal gap", exp_gap, gap_n, 1);
            if (cal_start === 1'b1 && crystal_osc_en === 1'b1) check_val("cal on crystal", 0, 1, 0);
            if (cal_done === 1'b1) begin
                check_val("cal busy", CAL_D, busy_n, 0);
                busy_n = 0;
                gap_n  = 0;
                gap_ok = 1'b1;
            end else begin
                gap_n++;
            end
            if (crystal_osc_en === 1'b1 && low_freq_clock_valid !== 1'b1) begin
                xs_n++;
            end else if (xs_n != 0) begin
                check_val("crystal wait", XS, xs_n, 0);
                xs_n = 0;
            end
        end
    end

    initial begin
        tick(10000);
        errors++;
        results();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        tick(3);
        sys_rst <= 1'b0;
        tick(3);
        check_val("rc source", 1, int'(low_freq_clock_valid === 1'b1 && crystal_osc_en === 1'b0), 0);
        irq  <= IRQ_NUM'(1) << ($unsigned($random(seed)) % IRQ_NUM);
        wfe  <= 1'b1;
        tick(1);
        irq  <= '0;
        pend <= 1'b1;
        tick(1);
        wfe  <= 1'b0;
        pend <= 1'b0;
        tick(4);
        for (k = 0; k < 3; k++) begin
            enter_doze();
            exp_state.push_back(4'b0001);
            if (k == 0) irq <= IRQ_NUM'(1) << ($unsigned($random(seed)) % IRQ_NUM);
            else if (k == 1) uart <= 1'b1;
            else radio <= 1'b1;
            tick(1);
            irq   <= '0;
            uart  <= 1'b0;
            radio <= 1'b0;
            settle();
        end
        for (k = 0; k < 4; k++) begin
            enter_doze();
            pin_wake(2'(k), 4'b0001);
        end
        exp_state.push_back(4'b0001);
        uart <= 1'b1;
        tick(1);
        uart <= 1'b0;
        settle();
        // Deep request wins over a wait point in the same cycle
        exp_state.push_back(4'b0100);
        deep_req <= 1'b1;
        wfe      <= 1'b1;
        tick(1);
        deep_req <= 1'b0;
        wfe      <= 1'b0;
        settle();
        irq <= 8'hff;
        tick(2);
        irq <= '0;
        tick(4);
        pin_wake(WAKE_ON_HIGH, 4'b1001);
        tick(3 * (CAL_I + CAL_D));
        cust    <= 1'b1;
        cal_iv  <= 32'h0000000a;
        exp_gap = CAL_MIN;
        gap_ok  = 1'b0;
        tick(4 * (CAL_MIN + CAL_D));
        cal_iv  <= 32'h00000050;
        exp_gap = 80;
        gap_ok  = 1'b0;
        tick(4 * (80 + CAL_D));
        cust    <= 1'b0;
        xsel    <= 1'b1;
        gap_ok  = 1'b0;
        tick(XS + CAL_I + CAL_D + 10);
        check_val("crystal ready", 1, int'(low_freq_clock_valid === 1'b1), 0);
        xsel    <= 1'b0;
        exp_gap = CAL_I;
        gap_ok  = 1'b0;
        tick(2 * (CAL_I + CAL_D) + 10);
        results();
    end
endmodule

// File: logic/power_mode_wake_control.sv
`timescale 1ns/1ps
// Operation
// - Any general pin can be enabled as a host wake source.
// - Each wake pin triggers on low level, high level or any change.
// - Exactly three power states: run, standby doze, deep sleep.
// - Wait-for-event point with nothing pending enters standby doze.
// - Any interrupt, serial or radio character included, returns doze to run.
// - Waking from deep sleep issues a full system reset.
// - Low-frequency clock comes from the RC oscillator unless crystal selected.
// - With RC source, calibration starts periodically, eight seconds by default.
// - Each calibration is held busy 16 to 17 ms before completing.
// - Calibration interval is configurable, never shorter than a quarter second.
// - Crystal gets a quarter second start-up before valid; no RC calibration.
module power_mode_wake_control
    import power_mode_pkg::*;
#(
    parameter logic [31:0] CAL_INTERVAL_CYC     =
        32'((CAL_INTERVAL_DEF_MS * CLK_FREQ_HZ) / 64'd1000),
    parameter logic [31:0] CAL_INTERVAL_MIN_CYC =
        32'((CAL_INTERVAL_MIN_MS * CLK_FREQ_HZ + 64'd999) / 64'd1000),
    parameter logic [31:0] CAL_DURATION_CYC     =
        32'((CAL_DURATION_MIN_US * CLK_FREQ_HZ + 64'd999999) / 64'd1000000),
    parameter logic [31:0] XTAL_STARTUP_CYC     =
        32'((XTAL_STARTUP_MS * CLK_FREQ_HZ + 64'd999) / 64'd1000)
)
(
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic [NUM_PINS-1:0]      general_pin,
    input  wire logic [NUM_PINS-1:0]      wake_enable,
    input  wire logic [NUM_PINS-1:0][1:0] wake_mode,
    input  wire logic                     wait_for_event_point,
    input  wire logic                     events_pending,
    input  wire logic [IRQ_NUM-1:0]       irq_lines,
    input  wire logic                     uart_rx_char,
    input  wire logic                     radio_rx_char,
    input  wire logic                     deep_sleep_req,
    input  wire logic                     crystal_select,
    input  wire logic                     cal_interval_custom_en,
    input  wire logic [31:0]              cal_interval,
    output logic                          run_active,
    output logic                          doze_active,
    output logic                          deep_active,
    output logic                          system_reset_req,
    output logic                          wake_event,
    output logic                          cal_start,
    output logic                          cal_busy,
    output logic                          cal_done,
    output logic                          crystal_osc_en,
    output logic                          low_freq_clock_valid
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        pstate_e     mode;
        logic        rst_pulse;
        logic        wake_seen;
        logic [31:0] cal_timer;
        logic        cal_busy;
        logic        cal_start;
        logic        cal_done;
        logic        xtal_sel;
        logic [31:0] xtal_timer;
        logic        xtal_ready;
        logic        lf_valid;
    } ctl_s;

    ctl_s                st;
    ctl_s                next_st;
    logic [NUM_PINS-1:0] wake_hit;
    logic                wake_any;
    logic                irq_any;
    logic [31:0]         interval_eff;

    // ----------------------------------------------------------------
    // Wake pin front end
    // ----------------------------------------------------------------
    wake_pin_detect u_wake (
        .clk_sys     (clk_sys),
        .sys_rst     (sys_rst),
        .general_pin (general_pin),
        .wake_enable (wake_enable),
        .wake_mode   (wake_mode),
        .wake_hit    (wake_hit)
    );

    assign wake_any = |wake_hit;
    assign irq_any  = (|irq_lines) | uart_rx_char | radio_rx_char;

    // Short requests are clamped up, so software cannot burn charge
    always_comb begin
        if (!cal_interval_custom_en) begin
            interval_eff = CAL_INTERVAL_CYC;
        end else if (cal_interval < CAL_INTERVAL_MIN_CYC) begin
            interval_eff = CAL_INTERVAL_MIN_CYC;
        end else begin
            interval_eff = cal_interval;
        end
    end

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st           = st;
        next_st.rst_pulse = 1'b0;
        next_st.cal_start = 1'b0;
        next_st.cal_done  = 1'b0;
        next_st.wake_seen = wake_any;

        // Power modes; deep sleep request outranks doze
        unique case (st.mode)
            P_RUN: begin
                if (deep_sleep_req) begin
                    next_st.mode = P_DEEP;
                end else if (wait_for_event_point && !events_pending && !irq_any) begin
                    next_st.mode = P_DOZE;
                end
            end
            P_DOZE: begin
                if (irq_any || wake_any) begin
                    next_st.mode = P_RUN;
                end
            end
            P_DEEP: begin
                if (wake_any) begin
                    next_st.mode      = P_RUN;
                    next_st.rst_pulse = 1'b1;
                end
            end
            default: next_st.mode = P_RUN;
        endcase

        // Clock source; crystal once selected, clock not valid until it has started
        next_st.xtal_sel = crystal_select;
        if (!st.xtal_sel) begin
            next_st.xtal_ready = 1'b0;
            next_st.xtal_timer = XTAL_STARTUP_CYC - 32'h1;
        end else if (!st.xtal_ready) begin
            if (st.xtal_timer == 32'h0) begin
                next_st.xtal_ready = 1'b1;
            end else begin
                next_st.xtal_timer = st.xtal_timer - 32'h1;
            end
        end
        next_st.lf_valid = next_st.xtal_sel ? next_st.xtal_ready : 1'b1;

        // Calibration only while RC is the source
        if (st.xtal_sel) begin
            next_st.cal_busy  = 1'b0;
            next_st.cal_timer = interval_eff - 32'h1;
        end else if (!st.cal_busy) begin
            if (st.cal_timer == 32'h0) begin
                next_st.cal_start = 1'b1;
                next_st.cal_busy  = 1'b1;
                next_st.cal_timer = CAL_DURATION_CYC - 32'h1;
            end else if (st.cal_timer >= interval_eff) begin
                next_st.cal_timer = interval_eff - 32'h1;
            end else begin
                next_st.cal_timer = st.cal_timer - 32'h1;
            end
        end else begin
            if (st.cal_timer == 32'h0) begin
                next_st.cal_busy  = 1'b0;
                next_st.cal_done  = 1'b1;
                next_st.cal_timer = interval_eff - 32'h1;
            end else begin
                next_st.cal_timer = st.cal_timer - 32'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st            <= '0;
            st.mode       <= P_RUN;
            st.cal_timer  <= CAL_INTERVAL_CYC - 32'h1;
            st.xtal_timer <= XTAL_STARTUP_CYC - 32'h1;
            st.lf_valid   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign run_active           = (st.mode == P_RUN);
    assign doze_active          = (st.mode == P_DOZE);
    assign deep_active          = (st.mode == P_DEEP);
    assign system_reset_req     = st.rst_pulse;
    assign wake_event           = st.wake_seen;
    assign cal_start            = st.cal_start;
    assign cal_busy             = st.cal_busy;
    assign cal_done             = st.cal_done;
    assign crystal_osc_en       = st.xtal_sel;
    assign low_freq_clock_valid = st.lf_valid;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [31:0] busy_len;
    logic [31:0] idle_len;
    logic [31:0] xtal_len;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busy_len <= 32'h0;
            idle_len <= 32'h0;
            xtal_len <= 32'h0;
        end else begin
            busy_len <= st.cal_busy ? busy_len + 32'h1 : 32'h0;
            idle_len <= (st.cal_busy || st.xtal_sel) ? 32'h0 : idle_len + 32'h1;
            xtal_len <= (st.xtal_sel && !st.xtal_ready) ? xtal_len + 32'h1 : 32'h0;
        end
    end

    a_one_state: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $onehot(st.mode))
        else $error("power state not one-hot");

    a_doze_entry: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (run_active && wait_for_event_point && !events_pending && !irq_any
         && !deep_sleep_req) |=> doze_active)
        else $error("doze not entered");

    a_doze_exit: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (doze_active && irq_any) |=> run_active && !system_reset_req)
        else $error("interrupt did not end doze");

    a_deep_reset: assert property (@(posedge clk_sys) disable iff (sys_rst)
        (deep_active && wake_any) |=> (system_reset_req && run_active) ##1 !system_reset_req)
        else $error("deep wake without single reset pulse");

    a_reset_cause: assert property (@(posedge clk_sys) disable iff (sys_rst)
        system_reset_req |-> $past(deep_active, 1))
        else $error("reset pulse outside deep wake");

    a_cal_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $fell(cal_busy) && cal_done |-> busy_len == CAL_DURATION_CYC)
        else $error("calibration length wrong");

    a_cal_spacing: assert property (@(posedge clk_sys) disable iff (sys_rst)
        cal_start && $past(idle_len, 1) != 32'h0 |-> $past(idle_len, 1) >= CAL_INTERVAL_MIN_CYC - 32'h1)
        else $error("calibration interval too short");

    a_no_cal_xtal: assert property (@(posedge clk_sys) disable iff (sys_rst)
        crystal_osc_en |=> !cal_start)
        else $error("calibration while crystal selected");

    a_xtal_wait: assert property (@(posedge clk_sys) disable iff (sys_rst)
        $rose(low_freq_clock_valid) && crystal_osc_en |-> xtal_len == XTAL_STARTUP_CYC)
        else $error("crystal start-up wait wrong");

endmodule

// File: logic/wake_pin_detect.sv
`timescale 1ns/1ps
module wake_pin_detect
    import power_mode_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     sys_rst,
    input  wire logic [NUM_PINS-1:0]      general_pin,
    input  wire logic [NUM_PINS-1:0]      wake_enable,
    input  wire logic [NUM_PINS-1:0][1:0] wake_mode,
    output logic      [NUM_PINS-1:0]      wake_hit
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic [NUM_PINS-1:0] prev;
        logic [NUM_PINS-1:0] hit;
        logic [1:0]          warm;
    } det_s;

    det_s                st;
    det_s                next_st;
    logic [NUM_PINS-1:0] hit_now;

    // ----------------------------------------------------------------
    // Per-pin trigger
    // ----------------------------------------------------------------
    // Only sync2 and prev are looked at; sync1 may be metastable
    for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
        always_comb begin
            hit_now[i] = 1'b0;
            if (wake_enable[i]) begin
                unique case (wake_mode[i])
                    WAKE_ON_LOW:    hit_now[i] = ~st.sync2[i];
                    WAKE_ON_HIGH:   hit_now[i] = st.sync2[i];
                    WAKE_ON_CHANGE: hit_now[i] = (st.warm == WARM_DONE) &&
                                                 (st.sync2[i] != st.prev[i]);
                    default:        hit_now[i] = 1'b0;
                endcase
            end
        end

        a_high_wake: assert property (@(posedge clk_sys) disable iff (sys_rst)
            (wake_enable[i] && wake_mode[i] == WAKE_ON_HIGH && general_pin[i])[*4]
            |=> wake_hit[i])
            else $error("high level wake not seen");

        a_sync_delay: assert property (@(posedge clk_sys) disable iff (sys_rst)
            (wake_hit[i] && $past(wake_mode[i], 1) == WAKE_ON_HIGH
             && $past(wake_enable[i], 1)) |-> $past(general_pin[i], 3))
            else $error("wake taken without synchronised level");
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_comb begin
        next_st       = st;
        next_st.sync1 = general_pin;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
        next_st.hit   = hit_now;
        if (st.warm != WARM_DONE) begin
            next_st.warm = st.warm + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign wake_hit = st.hit;

endmodule

// File: pkg/power_mode_pkg.sv
package power_mode_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_PINS = 32;
    localparam int IRQ_NUM  = 8;

    // ----------------------------------------------------------------
    // Wake trigger encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] WAKE_ON_LOW    = 2'h0;
    localparam logic [1:0] WAKE_ON_HIGH   = 2'h1;
    localparam logic [1:0] WAKE_ON_CHANGE = 2'h2;

    // ----------------------------------------------------------------
    // Timing, in the units printed
    // ----------------------------------------------------------------
    localparam longint CLK_FREQ_HZ         = 64'd200000000;
    localparam longint CAL_INTERVAL_DEF_MS = 64'd8000;
    localparam longint CAL_INTERVAL_MIN_MS = 64'd250;
    localparam longint CAL_DURATION_MIN_US = 64'd16000;
    localparam longint CAL_DURATION_MAX_US = 64'd17000;
    localparam longint XTAL_STARTUP_MS     = 64'd250;

    // ----------------------------------------------------------------
    // Warm-up count and power states
    // ----------------------------------------------------------------
    localparam logic [1:0] WARM_DONE = 2'h3;

    typedef enum logic [2:0] {
        P_RUN  = 3'h1,
        P_DOZE = 3'h2,
        P_DEEP = 3'h4
    } pstate_e;

endpackage
